// [core/fpc_top.sv]
`timescale 1ns/1ns
`default_nettype none
module fpc_top
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] io_addr,
   input  wire logic       io_rd,
   input  wire logic       io_wr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       kbc_gate_request,
   input  wire logic       kbc_reset_request_n,
   input  wire logic       coproc_error_in_n,
   output logic [7:0]      io_rdata,
   output logic            io_rdata_valid,
   output logic            a20_gate,
   output logic            cpu_reset_out,
   output logic            coproc_reset_out,
   output logic            cpu_ready_block,
   output logic            cpu_busy_out_n,
   output logic            cpu_operand_request,
   output logic            slow_speed
);
   logic       gate_int;
   logic       sys_reset_bit;
   logic       busy_latch;
   logic       cfg_locked;
   logic [7:0] cfg_index;
   logic [7:0] misc_config_reg;
   logic       special_port_disable;
   logic       coproc_sw_reset_block;

   logic rd_gate;
   logic wr_gate;
   logic rd_reset;
   logic wr_sys;
   logic wr_index;
   logic wr_data;
   logic wr_busy_clr;
   logic wr_npx_rst;
   logic wr_slow;
   logic wr_fast;
   logic wr_lock;
   logic wr_unlock;

   logic cpu_trig;
   logic cpu_busy;
   logic cpu_pulse;
   logic npx_trig;
   logic npx_busy;
   logic npx_pulse;
   logic npx_active;
   logic [7:0] next_rdata;

   assign special_port_disable  = misc_config_reg[fpc_pkg::MISC_PORT_DIS_BIT];
   assign coproc_sw_reset_block = misc_config_reg[fpc_pkg::MISC_NPX_BLK_BIT];

   fpc_io_decode u_decode
   (
      .io_addr     (io_addr),
      .io_rd       (io_rd),
      .io_wr       (io_wr),
      .ports_off   (special_port_disable),
      .cfg_locked  (cfg_locked),
      .rd_gate     (rd_gate),
      .wr_gate     (wr_gate),
      .rd_reset    (rd_reset),
      .wr_sys      (wr_sys),
      .wr_index    (wr_index),
      .wr_data     (wr_data),
      .wr_busy_clr (wr_busy_clr),
      .wr_npx_rst  (wr_npx_rst),
      .wr_slow     (wr_slow),
      .wr_fast     (wr_fast),
      .wr_lock     (wr_lock),
      .wr_unlock   (wr_unlock)
   );

   // Address gate: one state shared by both port mappings
   always_ff @(posedge clk)
   begin
      if (srst)
         gate_int <= 1'b0;
      else if (rd_gate)
         gate_int <= 1'b1;
      else if (wr_gate)
         gate_int <= 1'b0;
      else if (wr_sys)
         gate_int <= io_wdata[fpc_pkg::SYS_GATE_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         a20_gate <= 1'b0;
      else
         a20_gate <= gate_int | kbc_gate_request;
   end

   // Reset latch starts the delayed pulse only on a zero-to-one write
   always_ff @(posedge clk)
   begin
      if (srst)
         sys_reset_bit <= 1'b0;
      else if (wr_sys)
         sys_reset_bit <= io_wdata[fpc_pkg::SYS_RESET_BIT];
   end

   assign cpu_trig = rd_reset
                   | (wr_sys & io_wdata[fpc_pkg::SYS_RESET_BIT] & ~sys_reset_bit);

   fpc_pulse_gen
   #(
      .DELAY (fpc_pkg::CPU_RST_DELAY_CYC),
      .WIDTH (fpc_pkg::CPU_RST_WIDTH_CYC),
      .TAIL  (0)
   )
   u_cpu_rst
   (
      .clk    (clk),
      .srst   (srst),
      .trig   (cpu_trig),
      .busy   (cpu_busy),
      .pulse  (cpu_pulse),
      .active ()
   );

   always_ff @(posedge clk)
   begin
      if (srst)
         cpu_reset_out <= 1'b0;
      else
         cpu_reset_out <= cpu_pulse | ~kbc_reset_request_n;
   end

   // Coprocessor busy latch; a new error wins over a clear
   always_ff @(posedge clk)
   begin
      if (srst)
         busy_latch <= 1'b0;
      else if (~coproc_error_in_n)
         busy_latch <= 1'b1;
      else if (wr_busy_clr)
         busy_latch <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cpu_busy_out_n      <= 1'b1;
         cpu_operand_request <= 1'b0;
      end
      else
      begin
         cpu_busy_out_n      <= ~busy_latch;
         cpu_operand_request <= busy_latch;
      end
   end

   assign npx_trig = wr_npx_rst & ~coproc_sw_reset_block;

   fpc_pulse_gen
   #(
      .DELAY (0),
      .WIDTH (fpc_pkg::NPX_RST_WIDTH_CYC),
      .TAIL  (fpc_pkg::NPX_READY_HOLD_CYC)
   )
   u_npx_rst
   (
      .clk    (clk),
      .srst   (srst),
      .trig   (npx_trig),
      .busy   (npx_busy),
      .pulse  (npx_pulse),
      .active (npx_active)
   );

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         coproc_reset_out <= 1'b0;
         cpu_ready_block  <= 1'b0;
      end
      else
      begin
         coproc_reset_out <= npx_pulse;
         cpu_ready_block  <= npx_active;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         slow_speed <= 1'b0;
      else if (wr_slow)
         slow_speed <= 1'b1;
      else if (wr_fast)
         slow_speed <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cfg_locked <= 1'b0;
      else if (wr_unlock)
         cfg_locked <= 1'b0;
      else if (wr_lock)
         cfg_locked <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cfg_index <= fpc_pkg::INDEX_RESET;
      else if (wr_index)
         cfg_index <= io_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         misc_config_reg <= fpc_pkg::MISC_RESET;
      else if (wr_data && cfg_index == fpc_pkg::IDX_MISC_CONFIG)
         misc_config_reg <= io_wdata;
   end

   always_comb
   begin
      unique case (io_addr)
         fpc_pkg::PORT_SYS_CTRL:
            next_rdata = {fpc_pkg::SYS_ONES, gate_int, sys_reset_bit};
         fpc_pkg::PORT_CFG_INDEX:
            next_rdata = cfg_index;
         fpc_pkg::PORT_CFG_DATA:
            next_rdata = (cfg_index == fpc_pkg::IDX_MISC_CONFIG) ?
                         misc_config_reg : fpc_pkg::READ_ONES;
         default:
            next_rdata = fpc_pkg::READ_ONES;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         io_rdata       <= fpc_pkg::READ_ONES;
         io_rdata_valid <= 1'b0;
      end
      else
      begin
         io_rdata_valid <= io_rd;
         if (io_rd)
            io_rdata <= next_rdata;
      end
   end

   // Checks
   logic [7:0] cpu_len;
   logic [7:0] npx_len;
   localparam int CPU_DLY = fpc_pkg::CPU_RST_DELAY_CYC;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cpu_len <= 8'h00;
         npx_len <= 8'h00;
      end
      else
      begin
         cpu_len <= cpu_pulse ? cpu_len + 8'h01 : 8'h00;
         npx_len <= npx_pulse ? npx_len + 8'h01 : 8'h00;
      end
   end

   default clocking fpc_cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_GATE_READ: assert property (rd_gate |=> gate_int ##1 a20_gate)
      else $error("gate read did not open gate");
   AST_READ_ONES: assert property ((rd_gate | rd_reset) |=> io_rdata == 8'hFF)
      else $error("fast port read not all ones");
   AST_GATE_WRITE: assert property (wr_gate |=> !gate_int)
      else $error("gate write did not close gate");
   AST_GATE_OR: assert property (kbc_gate_request |=> a20_gate)
      else $error("keyboard gate request not passed");
   AST_GATE_RST: assert property (@(posedge clk) $past(srst) |-> !gate_int)
      else $error("gate not off after reset");
   AST_SYS_BIT1: assert property (rd_gate ##1 (!wr_gate && !wr_sys)[*3]
                                  ##1 (io_rd && io_addr == fpc_pkg::PORT_SYS_CTRL)
                                  |=> io_rdata[fpc_pkg::SYS_GATE_BIT])
      else $error("bit 1 not one after gate read");
   AST_SYS_GATE: assert property (wr_sys |=> gate_int == $past(io_wdata[1]))
      else $error("system port bit 1 not applied");
   AST_GATE_OFF: assert property ((special_port_disable && io_addr == 8'hEE && io_rd)
                                  |=> gate_int == $past(gate_int))
      else $error("gate port acted while disabled");
   AST_CPU_DELAY: assert property ((cpu_trig && !cpu_busy)
                                   |-> ##CPU_DLY !cpu_pulse ##1 cpu_pulse)
      else $error("cpu reset delay wrong");
   AST_CPU_WIDTH: assert property ($fell(cpu_pulse)
                                   |-> cpu_len == 8'(fpc_pkg::CPU_RST_WIDTH_CYC))
      else $error("cpu reset width not 16");
   AST_KBC_RST: assert property (!kbc_reset_request_n |=> cpu_reset_out)
      else $error("keyboard reset not passed");
   AST_NPX_WIDTH: assert property ($fell(npx_pulse)
                                   |-> npx_len == 8'(fpc_pkg::NPX_RST_WIDTH_CYC))
      else $error("coprocessor reset width not 40");
   AST_NPX_HOLD: assert property ($fell(npx_pulse) |-> ##49 npx_active ##1 !npx_active)
      else $error("ready hold not 50 cycles");
   AST_NPX_BLOCK: assert property ((wr_npx_rst && coproc_sw_reset_block && !npx_busy)
                                   |=> !npx_busy)
      else $error("blocked coprocessor reset fired");
   AST_NPX_READ: assert property ((io_rd && !npx_busy) |=> !npx_busy)
      else $error("read started coprocessor reset");
   AST_BUSY_CLR: assert property ((wr_busy_clr && coproc_error_in_n) |=> !busy_latch)
      else $error("busy latch not cleared");
   AST_LOCK: assert property ((cfg_locked && !special_port_disable && io_wr
                               && io_addr == 8'hEC) |=> $stable(cfg_index))
      else $error("locked index write taken");
   AST_SPEED: assert property ((wr_slow |=> slow_speed) and (wr_fast |=> !slow_speed))
      else $error("speed port not applied");

   COV_CPU_RST: cover property ($rose(cpu_pulse));
   COV_NPX_RST: cover property ($fell(npx_active));
   COV_GATE: cover property (rd_gate ##[1:8] wr_gate);
   COV_LOCK: cover property (wr_lock ##[1:20] wr_unlock);
endmodule : fpc_top
`default_nettype wire

// [inc/fpc_pkg.sv]
//Function
//- Gate port read opens gate, returns ones
//- Unlocked gate port write closes gate
//- Internal gate ORed with keyboard gate request
//- Internal gate control off after reset
//- System port bit 1 drives gate
//- One shared gate state, bit 1 reads it
//- Gate port works only when ports enabled
//- Reset port read resets CPU, returns ones
//- Fast reset ORed with keyboard reset request
//- Bit 0 write: delayed 16-cycle reset pulse
//- Reset bit holds until rewritten or reset
//- Disable kills reset port, system port stays
//- Busy clear write drops coprocessor busy latch
//- Coprocessor reset 40 cycles, ready held 50
//- Coprocessor reset ignored when block bit set
//- Fast/slow ports select speed, fast default
//- Speed ports need ports enabled, reads undefined
//- Unlock and lock ports steer configuration access
//- Locked: writes to index..reset ports ignored
//- Ports disabled: lock mechanism itself disabled
//- Port disable bit resets to zero
`default_nettype none
package fpc_pkg;

   localparam logic [7:0] PORT_SYS_CTRL     = 8'h92;
   localparam logic [7:0] PORT_CFG_INDEX    = 8'hEC;
   localparam logic [7:0] PORT_CFG_DATA     = 8'hED;
   localparam logic [7:0] PORT_FAST_GATE    = 8'hEE;
   localparam logic [7:0] PORT_FAST_RESET   = 8'hEF;
   localparam logic [7:0] PORT_BUSY_CLEAR   = 8'hF0;
   localparam logic [7:0] PORT_COPROC_RESET = 8'hF1;
   localparam logic [7:0] PORT_SLOW_SPEED   = 8'hF4;
   localparam logic [7:0] PORT_FAST_SPEED   = 8'hF5;
   localparam logic [7:0] PORT_CFG_LOCK     = 8'hF9;
   localparam logic [7:0] PORT_CFG_UNLOCK   = 8'hFB;

   localparam logic [7:0] IDX_MISC_CONFIG   = 8'h14;
   localparam int         MISC_PORT_DIS_BIT = 7;
   localparam int         MISC_NPX_BLK_BIT  = 6;
   localparam logic [7:0] MISC_RESET        = 8'h11;
   localparam logic [7:0] INDEX_RESET       = 8'h00;
   localparam int         SYS_GATE_BIT      = 1;
   localparam int         SYS_RESET_BIT     = 0;
   localparam logic [5:0] SYS_ONES          = 6'h3F;
   localparam logic [7:0] READ_ONES         = 8'hFF;

   localparam int CLK_PERIOD_NS       = 40;
   localparam int CPU_RST_DELAY_PS    = 6720000;
   localparam int CPU_RST_DELAY_CYC   =
      (CPU_RST_DELAY_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
   localparam int CPU_RST_WIDTH_CYC   = 16;
   localparam int NPX_RST_WIDTH_CYC   = 40;
   localparam int NPX_READY_HOLD_CYC  = 50;

endpackage : fpc_pkg
`default_nettype wire

// [core/fpc_io_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module fpc_io_decode
(
   input  wire logic [7:0] io_addr,
   input  wire logic       io_rd,
   input  wire logic       io_wr,
   input  wire logic       ports_off,
   input  wire logic       cfg_locked,
   output logic            rd_gate,
   output logic            wr_gate,
   output logic            rd_reset,
   output logic            wr_sys,
   output logic            wr_index,
   output logic            wr_data,
   output logic            wr_busy_clr,
   output logic            wr_npx_rst,
   output logic            wr_slow,
   output logic            wr_fast,
   output logic            wr_lock,
   output logic            wr_unlock
);
   logic on;
   logic wr_ok;

   function automatic logic fpc_hit(input logic [7:0] a, input logic [7:0] p);
      fpc_hit = (a == p);
   endfunction : fpc_hit

   assign on    = ~ports_off;
   // Lock has no force while the special ports are off
   assign wr_ok = io_wr & ~(cfg_locked & on);
   assign rd_gate     = io_rd & on & fpc_hit(io_addr, fpc_pkg::PORT_FAST_GATE);
   assign wr_gate     = wr_ok & on & fpc_hit(io_addr, fpc_pkg::PORT_FAST_GATE);
   assign rd_reset    = io_rd & on & fpc_hit(io_addr, fpc_pkg::PORT_FAST_RESET);
   assign wr_sys      = io_wr & fpc_hit(io_addr, fpc_pkg::PORT_SYS_CTRL);
   assign wr_index    = wr_ok & fpc_hit(io_addr, fpc_pkg::PORT_CFG_INDEX);
   assign wr_data     = wr_ok & fpc_hit(io_addr, fpc_pkg::PORT_CFG_DATA);
   assign wr_busy_clr = io_wr & fpc_hit(io_addr, fpc_pkg::PORT_BUSY_CLEAR);
   assign wr_npx_rst  = io_wr & fpc_hit(io_addr, fpc_pkg::PORT_COPROC_RESET);
   assign wr_slow     = io_wr & on & fpc_hit(io_addr, fpc_pkg::PORT_SLOW_SPEED);
   assign wr_fast     = io_wr & on & fpc_hit(io_addr, fpc_pkg::PORT_FAST_SPEED);
   assign wr_lock     = io_wr & on & fpc_hit(io_addr, fpc_pkg::PORT_CFG_LOCK);
   assign wr_unlock   = io_wr & on & fpc_hit(io_addr, fpc_pkg::PORT_CFG_UNLOCK);
endmodule : fpc_io_decode
`default_nettype wire

// [core/fpc_pulse_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module fpc_pulse_gen
#(
   parameter int DELAY = 0,
   parameter int WIDTH = 1,
   parameter int TAIL  = 0
)
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic trig,
   output logic      busy,
   output logic      pulse,
   output logic      active
);
   typedef enum logic [1:0] {FPC_IDLE, FPC_WAIT, FPC_PULSE, FPC_TAIL} fpc_pg_state_t;
   fpc_pg_state_t state;
   logic [7:0]    cnt;

   assign busy = (state != FPC_IDLE);

   // Triggers while a sequence runs are dropped
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state  <= FPC_IDLE;
         cnt    <= 8'h00;
         pulse  <= 1'b0;
         active <= 1'b0;
      end
      else
      begin
         unique case (state)
            FPC_IDLE:
               if (trig)
               begin
                  if (DELAY > 0)
                  begin
                     state <= FPC_WAIT;
                     cnt   <= 8'(DELAY - 1);
                  end
                  else
                  begin
                     state  <= FPC_PULSE;
                     cnt    <= 8'(WIDTH - 1);
                     pulse  <= 1'b1;
                     active <= 1'b1;
                  end
               end
            FPC_WAIT:
               if (cnt == 8'h00)
               begin
                  state  <= FPC_PULSE;
                  cnt    <= 8'(WIDTH - 1);
                  pulse  <= 1'b1;
                  active <= 1'b1;
               end
               else
                  cnt <= cnt - 8'h01;
            FPC_PULSE:
               if (cnt == 8'h00)
               begin
                  pulse <= 1'b0;
                  if (TAIL > 0)
                  begin
                     state <= FPC_TAIL;
                     cnt   <= 8'(TAIL - 1);
                  end
                  else
                  begin
                     state  <= FPC_IDLE;
                     active <= 1'b0;
                  end
               end
               else
                  cnt <= cnt - 8'h01;
            FPC_TAIL:
               if (cnt == 8'h00)
               begin
                  state  <= FPC_IDLE;
                  active <= 1'b0;
               end
               else
                  cnt <= cnt - 8'h01;
         endcase
      end
   end
endmodule : fpc_pulse_gen
`default_nettype wire

// [verification/fpc_host.sv]
`timescale 1ns/1ns
`default_nettype none
module fpc_host
(
   input  wire logic       clk,
   input  wire logic [7:0] io_rdata,
   input  wire logic       io_rdata_valid,
   output var logic [7:0]  io_addr,
   output var logic        io_rd,
   output var logic        io_wr,
   output var logic [7:0]  io_wdata
);
   initial
   begin
      io_addr  = 8'h00;
      io_rd    = 1'b0;
      io_wr    = 1'b0;
      io_wdata = 8'h00;
   end

   // Released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge clk);
      io_wr    <= 1'b0;
      io_addr  <= ~a;
      io_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge clk);
      io_rd   <= 1'b0;
      io_addr <= ~a;
      #1;
      d = io_rdata;
      v = io_rdata_valid;
   endtask : rd
endmodule : fpc_host
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, s); n_mismatch++; end end
module testbench;
   typedef struct packed
   {
      logic       wr;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] er;
      logic       ea;
      logic       es;
   } fpc_row_t;

   localparam fpc_row_t ROWS [24] = '{
      '{1'b0, 8'h92, 8'h00, 8'hFC, 1'b0, 1'b0}, '{1'b1, 8'hEC, 8'h14, 8'h00, 1'b0, 1'b0},
      '{1'b0, 8'hED, 8'h00, 8'h11, 1'b0, 1'b0}, '{1'b0, 8'hEE, 8'h00, 8'hFF, 1'b1, 1'b0},
      '{1'b0, 8'h92, 8'h00, 8'hFE, 1'b1, 1'b0}, '{1'b1, 8'hEE, 8'hA5, 8'h00, 1'b0, 1'b0},
      '{1'b1, 8'h92, 8'h02, 8'h00, 1'b1, 1'b0}, '{1'b1, 8'h92, 8'h00, 8'h00, 1'b0, 1'b0},
      '{1'b1, 8'hF4, 8'h00, 8'h00, 1'b0, 1'b1}, '{1'b1, 8'hF5, 8'h00, 8'h00, 1'b0, 1'b0},
      '{1'b1, 8'hF9, 8'h00, 8'h00, 1'b0, 1'b0}, '{1'b0, 8'hEE, 8'h00, 8'hFF, 1'b1, 1'b0},
      '{1'b1, 8'hEE, 8'h00, 8'h00, 1'b1, 1'b0}, '{1'b1, 8'hEC, 8'h00, 8'h00, 1'b1, 1'b0},
      '{1'b0, 8'hEC, 8'h00, 8'h14, 1'b1, 1'b0}, '{1'b1, 8'hFB, 8'h00, 8'h00, 1'b1, 1'b0},
      '{1'b1, 8'hEE, 8'h00, 8'h00, 1'b0, 1'b0}, '{1'b1, 8'hED, 8'h91, 8'h00, 1'b0, 1'b0},
      '{1'b0, 8'hEE, 8'h00, 8'hFF, 1'b0, 1'b0}, '{1'b1, 8'hF4, 8'h00, 8'h00, 1'b0, 1'b0},
      '{1'b1, 8'hF9, 8'h00, 8'h00, 1'b0, 1'b0}, '{1'b1, 8'hED, 8'h11, 8'h00, 1'b0, 1'b0},
      '{1'b0, 8'hEE, 8'h00, 8'hFF, 1'b1, 1'b0}, '{1'b1, 8'hEE, 8'h00, 8'h00, 1'b0, 1'b0}};

   logic       clk;
   logic       srst;
   logic [7:0] io_addr;
   logic       io_rd;
   logic       io_wr;
   logic [7:0] io_wdata;
   logic       kbc_gate_request;
   logic       kbc_reset_request_n;
   logic       coproc_error_in_n;
   logic [7:0] io_rdata;
   logic       io_rdata_valid;
   logic       a20_gate;
   logic       cpu_reset_out;
   logic       coproc_reset_out;
   logic       cpu_ready_block;
   logic       cpu_busy_out_n;
   logic       cpu_operand_request;
   logic       slow_speed;
   logic [2:0] pulses;
   int         n_mismatch;
   int         check_count;

   assign pulses = {cpu_ready_block, coproc_reset_out, cpu_reset_out};

   fpc_top DUT (.clk(clk), .srst(srst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
      .io_wdata(io_wdata), .kbc_gate_request(kbc_gate_request),
      .kbc_reset_request_n(kbc_reset_request_n), .coproc_error_in_n(coproc_error_in_n),
      .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .a20_gate(a20_gate),
      .cpu_reset_out(cpu_reset_out), .coproc_reset_out(coproc_reset_out),
      .cpu_ready_block(cpu_ready_block), .cpu_busy_out_n(cpu_busy_out_n),
      .cpu_operand_request(cpu_operand_request), .slow_speed(slow_speed));

   fpc_host host (.clk(clk), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
      .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : settle

   // Cycles from the take edge until the pulse rises, then its high cycles
   task automatic pulse(input int k, output int n, output int w);
      n = 0;
      w = 0;
      while (n < 300 && pulses[k] !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (w < 300 && pulses[k] === 1'b1)
      begin
         @(posedge clk);
         #1;
         w++;
      end
   endtask : pulse

   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end

   initial
   begin : main
      logic [7:0] d;
      logic       v;
      int         n;
      int         w;
      int         n2;
      int         w2;
      n_mismatch = 0;
      check_count = 0;
      srst = 1'b1;
      kbc_gate_request = 1'b0;
      kbc_reset_request_n = 1'b1;
      coproc_error_in_n = 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      foreach (ROWS[i])
      begin
         if (ROWS[i].wr)
            host.wr(ROWS[i].a, ROWS[i].d);
         else
         begin
            host.rd(ROWS[i].a, d, v);
            `CHK("rdata", ROWS[i].er, d);
            `CHK("valid", 1'b1, v);
         end
         settle(2);
         `CHK("a20", ROWS[i].ea, a20_gate);
         `CHK("slow", ROWS[i].es, slow_speed);
      end
      kbc_gate_request <= 1'b1;
      settle(3);
      `CHK("a20_kbc", 1'b1, a20_gate);
      kbc_gate_request <= 1'b0;
      host.rd(fpc_pkg::PORT_FAST_RESET, d, v);
      pulse(0, n, w);
      `CHK("ef_data", fpc_pkg::READ_ONES, d);
      `CHK("ef_delay", 1'b1, n >= fpc_pkg::CPU_RST_DELAY_CYC && n < 300);
      `CHK("ef_width", fpc_pkg::CPU_RST_WIDTH_CYC, w);
      host.wr(fpc_pkg::PORT_SYS_CTRL, 8'h01);
      pulse(0, n, w);
      `CHK("p92_delay", 1'b1, n >= fpc_pkg::CPU_RST_DELAY_CYC && n < 300);
      `CHK("p92_width", fpc_pkg::CPU_RST_WIDTH_CYC, w);
      host.rd(fpc_pkg::PORT_SYS_CTRL, d, v);
      `CHK("p92_hold", 8'hFD, d);
      host.wr(fpc_pkg::PORT_SYS_CTRL, 8'h00);
      kbc_reset_request_n <= 1'b0;
      settle(3);
      `CHK("kbc_reset", 1'b1, cpu_reset_out);
      kbc_reset_request_n <= 1'b1;
      settle(3);
      host.wr(fpc_pkg::PORT_CFG_DATA, 8'h91);
      host.rd(fpc_pkg::PORT_FAST_RESET, d, v);
      pulse(0, n, w);
      `CHK("ef_off", 300, n);
      host.wr(fpc_pkg::PORT_SYS_CTRL, 8'h01);
      pulse(0, n, w);
      `CHK("p92_on", fpc_pkg::CPU_RST_WIDTH_CYC, w);
      host.wr(fpc_pkg::PORT_SYS_CTRL, 8'h00);
      host.wr(fpc_pkg::PORT_CFG_DATA, 8'h11);
      coproc_error_in_n <= 1'b0;
      settle(1);
      coproc_error_in_n <= 1'b1;
      host.rd(fpc_pkg::PORT_BUSY_CLEAR, d, v);
      host.rd(fpc_pkg::PORT_COPROC_RESET, d, v);
      settle(3);
      `CHK("busy_held", 1'b0, cpu_busy_out_n);
      `CHK("oper_held", 1'b1, cpu_operand_request);
      `CHK("npx_rd", 1'b0, coproc_reset_out);
      host.wr(fpc_pkg::PORT_BUSY_CLEAR, 8'h00);
      settle(3);
      `CHK("busy_clr", 1'b1, cpu_busy_out_n);
      `CHK("oper_clr", 1'b0, cpu_operand_request);
      host.wr(fpc_pkg::PORT_COPROC_RESET, 8'h3C);
      fork
         pulse(1, n, w);
         pulse(2, n2, w2);
      join
      `CHK("npx_width", fpc_pkg::NPX_RST_WIDTH_CYC, w);
      `CHK("rdy_width", fpc_pkg::NPX_RST_WIDTH_CYC + fpc_pkg::NPX_READY_HOLD_CYC, w2);
      `CHK("rdy_start", n, n2);
      host.wr(fpc_pkg::PORT_CFG_DATA, 8'h51);
      host.wr(fpc_pkg::PORT_COPROC_RESET, 8'h00);
      pulse(1, n, w);
      `CHK("npx_block", 300, n);
      host.wr(fpc_pkg::PORT_CFG_DATA, 8'h11);
      host.wr(fpc_pkg::PORT_SLOW_SPEED, 8'h00);
      host.rd(fpc_pkg::PORT_FAST_GATE, d, v);
      srst <= 1'b1;
      settle(4);
      srst <= 1'b0;
      settle(2);
      `CHK("rst_slow", 1'b0, slow_speed);
      `CHK("rst_a20", 1'b0, a20_gate);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
